// ---- rtl/blre_led_reset_regs.v ----
`timescale 1ns/1ns
`default_nettype none
`include "blre_regs.vh"
module blre_led_reset_regs #(
	parameter CLK_MHZ = 100,
	parameter BLINK_CYCLES = (`BLRE_BLINK_NS / 1000) * CLK_MHZ
) (
	// clock and reset
	input wire sys_clk,
	input wire rst_n,
	// host i/o port access
	input wire [11:0] ioAddr,
	input wire ioWrite,
	input wire ioRead,
	input wire [7:0] ioWrData,
	output reg [7:0] ioRdData,
	// board status, asynchronous
	input wire boardInReset,
	input wire diskActive,
	input wire standby,
	input wire nearThermalLimit,
	input wire link10,
	input wire link100,
	input wire netTraffic,
	input wire defaultConfigJumper,
	// reset source pulses or levels, asynchronous
	input wire mainPowerFail,
	input wire corePowerFail,
	input wire nonStandbyPowerFail,
	input wire memPowerFail,
	input wire standbyPowerFail,
	input wire pciReset,
	input wire buttonReset,
	input wire buttonIsReset,
	// serial eeprom
	output reg romChipSelect,
	output reg romShiftClock,
	output reg romDataToward,
	input wire romDataFrom,
	// led, one bit per colour
	output reg ledRed,
	output reg ledGreen,
	output reg ledBlue
);
	// positions of the asynchronous inputs inside the synchroniser bank
	localparam NSYNC = 17;
	localparam S_DISK = 0;
	localparam S_STANDBY = 1;
	localparam S_THERMAL = 2;
	localparam S_LINK10 = 3;
	localparam S_LINK100 = 4;
	localparam S_TRAFFIC = 5;
	localparam S_JUMPER = 6;
	localparam S_MAIN = 7;
	localparam S_CORE = 8;
	localparam S_NONSTBY = 9;
	localparam S_MEM = 10;
	localparam S_STBY = 11;
	localparam S_PCI = 12;
	localparam S_BUTTON = 13;
	localparam S_BTNCFG = 14;
	localparam S_ROMDATA = 15;
	localparam S_INRESET = 16;
	localparam FLAG_W = 8;

	wire [NSYNC-1:0] asyncIn;
	assign asyncIn[S_DISK] = diskActive;
	assign asyncIn[S_STANDBY] = standby;
	assign asyncIn[S_THERMAL] = nearThermalLimit;
	assign asyncIn[S_LINK10] = link10;
	assign asyncIn[S_LINK100] = link100;
	assign asyncIn[S_TRAFFIC] = netTraffic;
	assign asyncIn[S_JUMPER] = defaultConfigJumper;
	assign asyncIn[S_MAIN] = mainPowerFail;
	assign asyncIn[S_CORE] = corePowerFail;
	assign asyncIn[S_NONSTBY] = nonStandbyPowerFail;
	assign asyncIn[S_MEM] = memPowerFail;
	assign asyncIn[S_STBY] = standbyPowerFail;
	assign asyncIn[S_PCI] = pciReset;
	assign asyncIn[S_BUTTON] = buttonReset;
	assign asyncIn[S_BTNCFG] = buttonIsReset;
	assign asyncIn[S_ROMDATA] = romDataFrom;
	assign asyncIn[S_INRESET] = boardInReset;

	// two flops per pin; only the second stage is ever read
	reg [NSYNC-1:0] syncA;
	reg [NSYNC-1:0] syncB;
	genvar sb;
	generate
		for (sb = 0; sb < NSYNC; sb = sb + 1) begin : syncBit
			always @(posedge sys_clk) begin
				syncA[sb] <= asyncIn[sb];
				syncB[sb] <= syncA[sb];
			end
		end
	endgenerate

	wire boardInResetS = syncB[S_INRESET];
	wire diskS = syncB[S_DISK];
	wire standbyS = syncB[S_STANDBY];
	wire thermalS = syncB[S_THERMAL];
	wire link10S = syncB[S_LINK10];
	wire link100S = syncB[S_LINK100];
	wire trafficS = syncB[S_TRAFFIC];
	wire jumperS = syncB[S_JUMPER];
	wire mainS = syncB[S_MAIN];
	wire coreS = syncB[S_CORE];
	wire nonStbyS = syncB[S_NONSTBY];
	wire memS = syncB[S_MEM];
	wire stbyS = syncB[S_STBY];
	wire pciS = syncB[S_PCI];
	wire buttonS = syncB[S_BUTTON];
	wire buttonIsResetS = syncB[S_BTNCFG];
	wire romDataFromS = syncB[S_ROMDATA];

	// stored register state
	reg [3:0] ledCode;
	reg jumperAtPowerUp;
	reg jumperCaught;
	reg [FLAG_W-1:0] flags;
	reg [31:0] blinkCount;
	reg blinkPhase;

	// address decode; accesses to any other port are ignored
	wire hitLed = (ioAddr == `BLRE_ADDR_LED);
	wire hitRst = (ioAddr == `BLRE_ADDR_RST);
	wire ledWr = ioWrite && hitLed;
	wire flagWr = ioWrite && hitRst;
	wire ledRd = ioRead && hitLed;
	wire flagRd = ioRead && hitRst;

	// next values of the shared led and eeprom register
	reg [3:0] next_ledCode;
	reg next_romChipSelect;
	reg next_romShiftClock;
	reg next_romDataToward;
	always @* begin
		next_ledCode = ledCode;
		next_romChipSelect = romChipSelect;
		next_romShiftClock = romShiftClock;
		next_romDataToward = romDataToward;
		if (ledWr) begin
			// bit 4 is the eeprom output, so a write never reaches it
			next_ledCode = ioWrData[`BLRE_LED_CODE_MSB:0];
			next_romChipSelect = ioWrData[`BLRE_ROM_CS_BIT];
			next_romShiftClock = ioWrData[`BLRE_ROM_SK_BIT];
			next_romDataToward = ioWrData[`BLRE_ROM_DI_BIT];
		end
	end

	// the eeprom lines are raw pins; software bit-bangs them through this register
	always @(posedge sys_clk) begin
		if (!rst_n) begin
			ledCode <= `BLRE_LED_AUTO;
			romChipSelect <= 1'b0;
			romShiftClock <= 1'b0;
			romDataToward <= 1'b0;
		end else begin
			ledCode <= next_ledCode;
			romChipSelect <= next_romChipSelect;
			romShiftClock <= next_romShiftClock;
			romDataToward <= next_romDataToward;
		end
	end

	// jumper caught once after each release of reset
	always @(posedge sys_clk) begin
		if (!rst_n) begin
			jumperCaught <= 1'b0;
			jumperAtPowerUp <= 1'b0;
		end else if (!jumperCaught) begin
			jumperCaught <= 1'b1;
			jumperAtPowerUp <= jumperS;
		end
	end

	wire setStby = stbyS;
	wire setMain = setStby | mainS;
	wire setMid = setMain | coreS | nonStbyS | memS;
	wire setPci = setMid | pciS;
	wire [FLAG_W-1:0] setVec;
	assign setVec[`BLRE_FLAG_MAIN] = setMain;
	assign setVec[`BLRE_FLAG_CORE] = setMid;
	assign setVec[`BLRE_FLAG_NONSTBY] = setMid;
	assign setVec[`BLRE_FLAG_MEM] = setMid;
	assign setVec[`BLRE_FLAG_STBY] = setStby;
	assign setVec[`BLRE_FLAG_RSVD] = 1'b0;
	assign setVec[`BLRE_FLAG_PCI] = setPci;
	// button flag only when button acts as reset
	assign setVec[`BLRE_FLAG_BUTTON] = buttonS & buttonIsResetS;

	// per-bit clear strobes from a write of ones
	wire [FLAG_W-1:0] clrVec = flagWr ? ioWrData : 8'h00;
	wire [FLAG_W-1:0] keepMask = `BLRE_FLAG_MASK;

	// flags are not touched by rst_n; they live on the standby rail
	genvar fb;
	generate
		for (fb = 0; fb < FLAG_W; fb = fb + 1) begin : flagBit
			always @(posedge sys_clk) begin
				// set wins over a clear in the same cycle
				if (!keepMask[fb]) begin
					flags[fb] <= 1'b0;
				end else if (setVec[fb]) begin
					flags[fb] <= 1'b1;
				end else if (clrVec[fb]) begin
					flags[fb] <= 1'b0;
				end
			end
		end
	endgenerate

	always @(posedge sys_clk) begin
		if (!rst_n) begin
			blinkCount <= 32'h0;
			blinkPhase <= 1'b0;
		end else if (blinkCount >= BLINK_CYCLES - 1) begin
			blinkCount <= 32'h0;
			blinkPhase <= ~blinkPhase;
		end else begin
			blinkCount <= blinkCount + 32'h1;
		end
	end

	reg [2:0] autoRgb;
	always @* begin
		if (boardInResetS || jumperAtPowerUp) begin
			autoRgb = `BLRE_RGB_RED;
		end else if (thermalS) begin
			autoRgb = `BLRE_RGB_WHITE;
		end else if (standbyS) begin
			autoRgb = `BLRE_RGB_YELLOW;
		end else if (diskS) begin
			autoRgb = `BLRE_RGB_BLUE;
		end else if (link100S) begin
			autoRgb = (trafficS && blinkPhase) ? `BLRE_RGB_OFF : `BLRE_RGB_MAGENTA;
		end else if (link10S) begin
			autoRgb = (trafficS && blinkPhase) ? `BLRE_RGB_OFF : `BLRE_RGB_CYAN;
		end else begin
			autoRgb = `BLRE_RGB_GREEN;
		end
	end

	// manual code decode; codes 0x01 to 0x07 fall back to automatic
	reg [2:0] next_rgb;
	always @* begin
		case (ledCode[`BLRE_LED_MANUAL_BIT])
			1'b1: begin
				next_rgb = ledCode[2:0];
			end
			default: begin
				next_rgb = autoRgb;
			end
		endcase
	end

	// read data is a one-cycle answer, zero between reads
	reg [FLAG_W-1:0] next_rdData;
	always @* begin
		next_rdData = 8'h00;
		if (ledRd) begin
			next_rdData = {romChipSelect, romShiftClock, romDataToward, romDataFromS, ledCode};
		end else if (flagRd) begin
			next_rdData = flags;
		end
	end

	always @(posedge sys_clk) begin
		if (!rst_n) begin
			ledRed <= 1'b0;
			ledGreen <= 1'b0;
			ledBlue <= 1'b0;
			ioRdData <= 8'h00;
		end else begin
			ledRed <= next_rgb[2];
			ledGreen <= next_rgb[1];
			ledBlue <= next_rgb[0];
			ioRdData <= next_rdData;
		end
	end
endmodule
`default_nettype wire

// ---- rtl/blre_regs.vh ----
`ifndef BLRE_REGS_VH
`define BLRE_REGS_VH
`define BLRE_ADDR_LED 12'h456
`define BLRE_ADDR_RST 12'h457
`define BLRE_LED_AUTO 4'h0
`define BLRE_LED_OFF 4'h8
`define BLRE_LED_MANUAL_BIT 3
`define BLRE_LED_CODE_MSB 3
`define BLRE_ROM_CS_BIT 7
`define BLRE_ROM_SK_BIT 6
`define BLRE_ROM_DI_BIT 5
`define BLRE_ROM_DO_BIT 4
`define BLRE_FLAG_MAIN 7
`define BLRE_FLAG_CORE 6
`define BLRE_FLAG_NONSTBY 5
`define BLRE_FLAG_MEM 4
`define BLRE_FLAG_STBY 3
`define BLRE_FLAG_RSVD 2
`define BLRE_FLAG_PCI 1
`define BLRE_FLAG_BUTTON 0
`define BLRE_FLAG_MASK 8'hFB
`define BLRE_RGB_OFF 3'h0
`define BLRE_RGB_BLUE 3'h1
`define BLRE_RGB_GREEN 3'h2
`define BLRE_RGB_CYAN 3'h3
`define BLRE_RGB_RED 3'h4
`define BLRE_RGB_MAGENTA 3'h5
`define BLRE_RGB_YELLOW 3'h6
`define BLRE_RGB_WHITE 3'h7
`define BLRE_BLINK_NS 250000000
`endif

// ---- dv/blre_regs_chk.sv ----
`timescale 1ns/1ns
`default_nettype none
module blre_regs_chk (
	// clock and reset
	input wire logic sys_clk, rst_n,
	// host access
	input wire logic [11:0] ioAddr,
	input wire logic ioWrite, ioRead,
	input wire logic [7:0] ioWrData, ioRdData,
	// eeprom and led pins
	input wire logic romChipSelect, romShiftClock, romDataToward, ledRed, ledGreen, ledBlue
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	wire wLed = ioWrite && ioAddr == 12'h456;
	wire rMap = ioAddr == 12'h456 || ioAddr == 12'h457;
	chk_rd_unmapped: assert property (ioRead && !rMap |=> ioRdData == 8'h00)
		else $error("unmapped read not zero");
	chk_rd_idle: assert property (!ioRead |=> ioRdData == 8'h00)
		else $error("read data not idle");
	chk_flag_reserved: assert property (ioRead && ioAddr == 12'h457 |=> !ioRdData[2])
		else $error("reserved flag set");
	chk_rom_write: assert property (wLed |=> {romChipSelect, romShiftClock, romDataToward} == $past(ioWrData[7:5]))
		else $error("eeprom pins not written");
	chk_rom_hold: assert property (!wLed |=> $stable({romChipSelect, romShiftClock, romDataToward}))
		else $error("eeprom pins moved");
	chk_reg_readback: assert property (wLed ##1 ioRead && !ioWrite && ioAddr == 12'h456 |=>
		{ioRdData[7:5], ioRdData[3:0]} == {$past(ioWrData[7:5], 2), $past(ioWrData[3:0], 2)})
		else $error("led register readback wrong");
	chk_manual_led: assert property (wLed && ioWrData[3] ##1 !wLed |=> {ledRed, ledGreen, ledBlue} == $past(ioWrData[2:0], 2))
		else $error("manual colour wrong");
	chk_reset_clear: assert property ($rose(rst_n) |-> !(ledRed || ledGreen || ledBlue || romChipSelect || romDataToward))
		else $error("outputs not cleared by reset");
	cover property (wLed && ioWrData[3]);
	cover property (ioRead && ioAddr == 12'h457);
	cover property ($rose(romChipSelect));
endmodule
`default_nettype wire

// ---- dv/blre_rom_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module blre_rom_model (
	// eeprom pins
	input wire logic cs, sk, di,
	output logic dout
);
	logic [7:0] sr = 8'hA5;
	logic last = 1'b0;
	always @(posedge sk) if (cs) sr <= {sr[6:0], di};
	always @(negedge cs) last <= sr[7];
	// released output holds the inverse of the bit latched when cs fell
	assign dout = cs ? sr[7] : ~last;
endmodule
`default_nettype wire

// ---- dv/tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	logic sys_clk = 0, rst_n = 0, ioWrite = 0, ioRead = 0, rdD = 0, btnCfg = 1, romOut, cs, sk, di, r, g, b;
	logic traffic = 0, jumper = 0, sawOff, sawOn;
	logic [11:0] ioAddr = 0;
	logic [7:0] ioWrData = 0, ioRdData, rnd;
	logic [6:0] src = 0;
	logic [5:0] st = 0;
	logic [15:0] q[$], n;
	logic [7:0] flagExp [8] = '{8'hF2, 8'h72, 8'h72, 8'h72, 8'hFA, 8'h02, 8'h01, 8'h00};
	logic [2:0] autoExp [7] = '{3'h4, 3'h7, 3'h6, 3'h1, 3'h5, 3'h3, 3'h2};
	integer err_total = 0, samples_checked = 0, cyc = 0, seed = 32'hde2a5ef2, i;
	blre_led_reset_regs #(.BLINK_CYCLES(4)) blre_led_reset_regs_inst (.sys_clk(sys_clk), .rst_n(rst_n),
		.ioAddr(ioAddr), .ioWrite(ioWrite), .ioRead(ioRead), .ioWrData(ioWrData), .ioRdData(ioRdData),
		.boardInReset(st[5]), .nearThermalLimit(st[4]), .standby(st[3]), .diskActive(st[2]), .link100(st[1]),
		.link10(st[0]), .netTraffic(traffic), .defaultConfigJumper(jumper), .mainPowerFail(src[6]),
		.corePowerFail(src[5]), .nonStandbyPowerFail(src[4]), .memPowerFail(src[3]), .standbyPowerFail(src[2]),
		.pciReset(src[1]), .buttonReset(src[0]), .buttonIsReset(btnCfg), .romChipSelect(cs),
		.romShiftClock(sk), .romDataToward(di), .romDataFrom(romOut), .ledRed(r), .ledGreen(g), .ledBlue(b));
	blre_rom_model blre_rom_model_inst (.cs(cs), .sk(sk), .di(di), .dout(romOut));
	initial forever #5 sys_clk = ~sys_clk;
	task chk(input [7:0] s, e);
		samples_checked++;
		if (s !== e) begin
			err_total++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task results;
		$display("mismatches=%0d checks=%0d", err_total, samples_checked);
		if (err_total == 0 && samples_checked > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// each task drives both strobes so back-to-back accesses never assign twice
	task wr(input [11:0] a, input [7:0] d);
		ioAddr <= a; ioWrData <= d; ioWrite <= 1; ioRead <= 0; @(posedge sys_clk);
	endtask
	task rd(input [11:0] a, input [7:0] e, m);
		ioAddr <= a; ioRead <= 1; ioWrite <= 0; q.push_back({m, e}); @(posedge sys_clk);
	endtask
	task idle(input integer k);
		ioWrite <= 0; ioRead <= 0; repeat (k) @(posedge sys_clk);
	endtask
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			err_total++;
			results;
		end
		rdD <= ioRead;
		if (rdD) begin
			n = q.pop_front();
			chk(ioRdData & n[15:8], n[7:0] & n[15:8]);
		end
	end
	initial begin
		repeat (5) @(posedge sys_clk);
		rst_n <= 1;
		idle(2);
		// flags power up unknown, so clear them first
		wr(12'h457, 8'hFF);
		rd(12'h457, 8'h00, 8'hFF);
		for (i = 0; i < 8; i++) begin
			btnCfg <= (i != 7);
			idle(3);
			src <= 7'h01 << (i == 7 ? 0 : 6 - i);
			idle(3);
			src <= 7'h00;
			idle(4);
			rd(12'h457, flagExp[i], 8'hFF);
			if (i == 4) wr(12'h457, 8'h0A);
			if (i == 4) rd(12'h457, 8'hF0, 8'hFF);
			wr(12'h457, 8'hFF);
			rd(12'h457, 8'h00, 8'hFF);
		end
		wr(12'h455, 8'hFF);
		rd(12'h455, 8'h00, 8'hFF);
		for (i = 8; i < 16; i++) begin
			rnd = $random(seed);
			wr(12'h456, {rnd[7:4], i[3:0]});
			rd(12'h456, {rnd[7:5], 1'b0, i[3:0]}, 8'hEF);
			idle(2);
			chk({5'h00, r, g, b}, {5'h00, i[2:0]});
			chk({5'h00, cs, sk, di}, {5'h00, rnd[7:5]});
			rd(12'h456, {rnd[7:5], romOut, i[3:0]}, 8'hFF);
		end
		// colour change with the eeprom bits written back as they stand
		wr(12'h456, {rnd[7:5], 5'h0E});
		idle(2);
		chk({5'h00, cs, sk, di}, {5'h00, rnd[7:5]});
		wr(12'h456, {rnd[7:5], 5'h00});
		// a flag must survive a mid-run reset; the jumper is fitted across it
		wr(12'h457, 8'hFF);
		src <= 7'h02;
		idle(3);
		src <= 7'h00;
		jumper <= 1;
		idle(4);
		rst_n <= 0;
		idle(3);
		rst_n <= 1;
		idle(2);
		rd(12'h457, 8'h02, 8'hFF);
		idle(2);
		chk({5'h00, r, g, b}, {5'h00, 3'h4});
		jumper <= 0;
		idle(4);
		rst_n <= 0;
		idle(3);
		rst_n <= 1;
		idle(2);
		for (i = 0; i < 7; i++) begin
			st <= (i == 6) ? 6'h00 : 6'h20 >> i;
			idle(6);
			chk({5'h00, r, g, b}, {5'h00, autoExp[i]});
		end
		// traffic on a fast link must blink between magenta and off
		st <= 6'h02;
		traffic <= 1;
		idle(6);
		sawOff = 0;
		sawOn = 0;
		repeat (8) begin
			@(posedge sys_clk);
			if ({r, g, b} === 3'h0) sawOff = 1;
			if ({r, g, b} === 3'h5) sawOn = 1;
		end
		chk({6'h00, sawOff, sawOn}, 8'h03);
		traffic <= 0;
		idle(2);
		results;
	end
endmodule
bind blre_led_reset_regs blre_regs_chk blre_regs_chk_inst (.*);
`default_nettype wire
